// [src/sea_defs.svh]
// Function
// RULE_01: Respond only when type nibble matches.
// RULE_02: Chip-select bits must equal select pins.
// RULE_03: Select bit zero: 1 reads, 0 writes.
// RULE_04: Acknowledge on match, else standby.
// RULE_05: Master opens with start, select MSB first.
// RULE_06: Write select, then two acked address bytes.
// RULE_07: Protect during address phase blocks data.
// RULE_08: Sixteen-bit address, high byte first.
// RULE_09: Only stop after data ack starts write.
// RULE_10: Counter ends one past last modified.
// RULE_11: Busy write: output off, bus ignored.
// RULE_12: Page holds 128 bytes within one row.
// RULE_13: Page writes wrap low seven address bits.
// RULE_14: Data acked only while protect is low.
// RULE_15: Six check bits correct word errors.
// RULE_16: Any byte write rewrites whole word.
// RULE_17: No select ack while busy, ack after.
// RULE_18: Reads ignore the protect input.
// RULE_19: Counter advances after each read byte.
// RULE_20: Random read via dummy write, restart.
// RULE_21: Byte write one byte; reads one or more.
// RULE_22: Start/stop are data edges, clock high.
// RULE_23: Master nack on read ends transfer.
// RULE_24: Plain read uses current counter address.
// RULE_25: Sequential read wraps to address zero.
// RULE_26: Busy for write time, then commit page; code commits the page during the first 32 busy cycles.
// RULE_27: Counter persists between transactions.
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH
`define SEA_CLK_PERIOD_NS 40
`define SEA_WRITE_TIME_NS 5000000
`define SEA_WRITE_CYCLES (`SEA_WRITE_TIME_NS / `SEA_CLK_PERIOD_NS)
`define SEA_BIT_ACK 4'h8
`define SEA_BIT_END 4'h9
`define SEA_PAGE_WORDS 6'h20
`define SEA_ERASED_WORD 32'hffffffff
`define SEA_RESET_ADDR 16'h0000
`endif

// [src/sea_pkg.sv]
package sea_pkg;
   // Bus sequencer states, Gray along the write path
   typedef enum logic [2:0] {
      SEA_IDLE = 3'h0,
      SEA_DEV  = 3'h1,
      SEA_AHI  = 3'h3,
      SEA_ALO  = 3'h2,
      SEA_WDAT = 3'h6,
      SEA_RDAT = 3'h4
   } sea_state_t;
   // One stored word: data plus check bits
   typedef logic [37:0] sea_code_t;
endpackage

// [src/sea_eeprom.sv]
`include "sea_defs.svh"
module sea_eeprom #(
   parameter logic [3:0] DEV_TYPE_ID  = 4'h5, // Arbitrary value
   parameter int         WRITE_CYCLES = `SEA_WRITE_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Two-wire bus
   input  wire logic scl,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // Straps and protection
   input  wire logic chip_select_pin_0,
   input  wire logic chip_select_pin_1,
   input  wire logic chip_select_pin_2,
   input  wire logic write_protect_input,
   // Status
   output logic      write_busy
);

   sea_pkg::sea_state_t state_reg;
   logic [3:0]          cnt_reg;
   logic [7:0]          shift_reg;
   logic [7:0]          tx_reg;
   logic                rw_reg;
   logic [7:0]          addr_hi_reg;
   logic [15:0]         addr_reg;
   logic                armed_reg;
   logic                wp_seen_reg;
   logic                scl_q;
   logic                sda_q;
   logic [23:0]         timer_reg;
   logic [5:0]          commit_reg;
   logic [7:0]          page_buf [128];
   logic [127:0]        page_mask;
   sea_pkg::sea_code_t  mem [16384];
   logic [16383:0]      word_valid;

   logic                scl_rise;
   logic                scl_fall;
   logic                start_det;
   logic                stop_det;
   logic                byte_end;
   logic                ack_end;
   logic                dev_match;
   logic                wr_take;
   logic                ld_tx;
   logic                go_write;
   logic [31:0]         rd_word;
   logic [7:0]          rd_byte;
   logic [13:0]         cm_index;
   logic [3:0]          cm_mask;
   logic [31:0]         cm_old;
   logic [31:0]         cm_new;

   // Hamming encode: check bits at power-of-two positions
   function automatic sea_pkg::sea_code_t ecc_encode(input logic [31:0] d);
      sea_pkg::sea_code_t c;
      int                 di;
      c  = '0;
      di = 0;
      for (int p = 1; p <= 38; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p-1] = d[di];
            di++;
         end
      end
      for (int i = 0; i < 6; i++) begin
         for (int p = 1; p <= 38; p++) begin
            if (p[i] && ((p & (p - 1)) != 0)) begin
               c[(1 << i) - 1] = c[(1 << i) - 1] ^ c[p-1];
            end
         end
      end
      return c;
   endfunction

   // Syndrome decode: flips one faulty bit, extracts data
   function automatic logic [31:0] ecc_decode(input sea_pkg::sea_code_t cw);
      sea_pkg::sea_code_t c;
      logic [5:0]         syn;
      logic [31:0]        d;
      int                 di;
      c   = cw;
      syn = '0;
      d   = '0;
      di  = 0;
      for (int p = 1; p <= 38; p++) begin
         if (c[p-1]) begin
            syn = syn ^ p[5:0];
         end
      end
      if (syn != 6'h00 && syn <= 6'h26) begin
         c[syn-6'h01] = ~c[syn-6'h01];
      end
      for (int p = 1; p <= 38; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[di] = c[p-1];
            di++;
         end
      end
      return d;
   endfunction

   // Bus edge and condition detection
   assign scl_rise  = scl & ~scl_q;
   assign scl_fall  = ~scl & scl_q;
   assign start_det = scl & scl_q & sda_q & ~sda_in; // RULE_22
   assign stop_det  = scl & scl_q & ~sda_q & sda_in; // RULE_22
   assign byte_end  = scl_fall && cnt_reg == `SEA_BIT_ACK;
   assign ack_end   = scl_fall && cnt_reg == `SEA_BIT_END;

   // Select byte decode against type and straps
   assign dev_match = shift_reg[7:4] == DEV_TYPE_ID && // RULE_01
                      shift_reg[3:1] == {chip_select_pin_2,
                                         chip_select_pin_1,
                                         chip_select_pin_0} && // RULE_02
                      !write_busy; // RULE_17

   // Byte strobes for the data path
   assign wr_take  = byte_end && state_reg == sea_pkg::SEA_WDAT &&
                     !wp_seen_reg; // RULE_14
   assign ld_tx    = ack_end && ((state_reg == sea_pkg::SEA_DEV && rw_reg) ||
                                 state_reg == sea_pkg::SEA_RDAT); // RULE_18
   assign go_write = stop_det && armed_reg && !write_busy; // RULE_09

   // Corrected read data at the counter address
   assign rd_word = word_valid[addr_reg[15:2]] ?
                    ecc_decode(mem[addr_reg[15:2]]) : `SEA_ERASED_WORD; // RULE_15
   assign rd_byte = rd_word[{addr_reg[1:0], 3'h0} +: 8];

   // Word merge for the commit walk
   always_comb begin
      cm_index = {addr_reg[15:7], commit_reg[4:0]};
      cm_mask  = page_mask[{commit_reg[4:0], 2'h0} +: 4];
      cm_old   = word_valid[cm_index] ?
                 ecc_decode(mem[cm_index]) : `SEA_ERASED_WORD;
      cm_new   = cm_old;
      for (int j = 0; j < 4; j++) begin
         if (cm_mask[j]) begin // RULE_16
            cm_new[j*8 +: 8] = page_buf[{commit_reg[4:0], 2'(j)}];
         end
      end
   end

   // Previous bus samples
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   // Bus sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= sea_pkg::SEA_IDLE;
         cnt_reg     <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         rw_reg      <= 1'b0;
         addr_hi_reg <= 8'h00;
         sda_oe      <= 1'b0;
      end else if (write_busy || stop_det || go_write) begin
         state_reg <= sea_pkg::SEA_IDLE; // RULE_11
         sda_oe    <= 1'b0;
      end else if (start_det) begin
         state_reg <= sea_pkg::SEA_DEV; // RULE_05
         cnt_reg   <= 4'h0;
         sda_oe    <= 1'b0;
      end else if (state_reg != sea_pkg::SEA_IDLE && scl_rise) begin
         if (cnt_reg < `SEA_BIT_ACK) begin
            shift_reg <= {shift_reg[6:0], sda_in};
         end
         if (cnt_reg < `SEA_BIT_END) begin
            cnt_reg <= cnt_reg + 4'h1;
         end
         if (state_reg == sea_pkg::SEA_RDAT && cnt_reg == `SEA_BIT_ACK &&
             sda_in) begin
            state_reg <= sea_pkg::SEA_IDLE; // RULE_23
         end
      end else if (state_reg != sea_pkg::SEA_IDLE && scl_fall) begin
         if (byte_end) begin
            unique case (state_reg)
               sea_pkg::SEA_DEV: begin
                  if (dev_match) begin
                     sda_oe <= 1'b1; // RULE_04
                     rw_reg <= shift_reg[0]; // RULE_03 RULE_20
                  end else begin
                     state_reg <= sea_pkg::SEA_IDLE; // RULE_04
                  end
               end
               sea_pkg::SEA_AHI: begin
                  sda_oe      <= 1'b1; // RULE_06
                  addr_hi_reg <= shift_reg; // RULE_08
               end
               sea_pkg::SEA_ALO: sda_oe <= 1'b1; // RULE_06
               sea_pkg::SEA_WDAT: sda_oe <= !wp_seen_reg; // RULE_07
               sea_pkg::SEA_RDAT: sda_oe <= 1'b0;
               default: state_reg <= sea_pkg::SEA_IDLE;
            endcase
         end else if (ack_end) begin
            cnt_reg <= 4'h0;
            sda_oe  <= 1'b0;
            unique case (state_reg)
               sea_pkg::SEA_DEV: state_reg <= rw_reg ? sea_pkg::SEA_RDAT :
                                                      sea_pkg::SEA_AHI;
               sea_pkg::SEA_AHI: state_reg <= sea_pkg::SEA_ALO;
               sea_pkg::SEA_ALO: state_reg <= sea_pkg::SEA_WDAT;
               sea_pkg::SEA_WDAT: state_reg <= sea_pkg::SEA_WDAT;
               sea_pkg::SEA_RDAT: state_reg <= sea_pkg::SEA_RDAT;
               default: state_reg <= sea_pkg::SEA_IDLE;
            endcase
            if (ld_tx) begin
               tx_reg <= rd_byte; // RULE_24
               sda_oe <= ~rd_byte[7];
            end
         end else if (state_reg == sea_pkg::SEA_RDAT &&
                      cnt_reg != 4'h0) begin
            // Shift out bits six down to zero
            sda_oe <= ~tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   // Protect level seen from start to address end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_seen_reg <= 1'b0;
      end else if (start_det) begin
         wp_seen_reg <= write_protect_input; // RULE_07
      end else if (state_reg == sea_pkg::SEA_DEV ||
                   state_reg == sea_pkg::SEA_AHI ||
                   state_reg == sea_pkg::SEA_ALO) begin
         wp_seen_reg <= wp_seen_reg | write_protect_input; // RULE_07
      end
   end

   // Write trigger armed only in the slot after a data ack
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg <= 1'b0;
      end else if (start_det || stop_det || write_busy) begin
         armed_reg <= 1'b0;
      end else if (ack_end && state_reg == sea_pkg::SEA_WDAT) begin
         armed_reg <= |page_mask; // RULE_09
      end else if (scl_fall) begin
         armed_reg <= 1'b0; // RULE_09
      end
   end

   // Address counter, kept across transactions
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= `SEA_RESET_ADDR; // RULE_27
      end else if (byte_end && state_reg == sea_pkg::SEA_ALO) begin
         addr_reg <= {addr_hi_reg, shift_reg}; // RULE_08
      end else if (wr_take) begin
         addr_reg[6:0] <= addr_reg[6:0] + 7'h01; // RULE_13 RULE_10
      end else if (ld_tx) begin
         addr_reg <= addr_reg + 16'h0001; // RULE_19 RULE_25
      end
   end

   // Page latch, one row of 128 bytes
   always_ff @(posedge sys_clk) begin
      if (wr_take) begin
         page_buf[addr_reg[6:0]] <= shift_reg; // RULE_12 RULE_21
      end
   end

   // Bytes latched for the coming write cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_mask <= '0;
      end else if (wr_take) begin
         page_mask[addr_reg[6:0]] <= 1'b1;
      end else if ((start_det && !write_busy) ||
                   (write_busy && timer_reg == 24'(WRITE_CYCLES - 1))) begin
         page_mask <= '0;
      end
   end

   // Internal write timer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_busy <= 1'b0;
         timer_reg  <= 24'h000000;
         commit_reg <= 6'h00;
      end else if (go_write) begin
         write_busy <= 1'b1; // RULE_26
         timer_reg  <= 24'h000000;
         commit_reg <= 6'h00;
      end else if (write_busy) begin
         timer_reg <= timer_reg + 24'h000001;
         if (commit_reg != `SEA_PAGE_WORDS) begin
            commit_reg <= commit_reg + 6'h01;
         end
         if (timer_reg == 24'(WRITE_CYCLES - 1)) begin
            write_busy <= 1'b0; // RULE_26
         end
      end
   end

   // Array commit, one word per cycle
   always_ff @(posedge sys_clk) begin
      if (write_busy && commit_reg != `SEA_PAGE_WORDS && |cm_mask) begin
         mem[cm_index] <= ecc_encode(cm_new); // RULE_15 RULE_16
      end
   end

   // Words holding programmed data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_valid <= '0;
      end else if (write_busy && commit_reg != `SEA_PAGE_WORDS &&
                   |cm_mask) begin
         word_valid[cm_index] <= 1'b1;
      end
   end

   // Open-drain data level, only low is ever driven
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   property p_busy_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      write_busy |-> !sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) // RULE_11
      else $error("data driven during write cycle");

   property p_sel_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      (byte_end && state_reg == sea_pkg::SEA_DEV && !stop_det &&
       !start_det && dev_match) |=> sda_oe;
   endproperty
   a_sel_ack: assert property (p_sel_ack) // RULE_04
      else $error("matching select not acknowledged");

   property p_sel_miss;
      @(posedge sys_clk) disable iff (!rst_n)
      (byte_end && state_reg == sea_pkg::SEA_DEV && !dev_match)
      |=> (!sda_oe && state_reg == sea_pkg::SEA_IDLE);
   endproperty
   a_sel_miss: assert property (p_sel_miss) // RULE_01 RULE_02
      else $error("mismatched select not released");

   property p_wp_nack;
      @(posedge sys_clk) disable iff (!rst_n)
      (byte_end && state_reg == sea_pkg::SEA_WDAT && wp_seen_reg)
      |=> !sda_oe ##1 !sda_oe;
   endproperty
   a_wp_nack: assert property (p_wp_nack) // RULE_07
      else $error("protected data byte acknowledged");

   property p_rd_inc;
      @(posedge sys_clk) disable iff (!rst_n)
      (ld_tx && !stop_det && !start_det && !write_busy)
      |=> addr_reg == $past(addr_reg) + 16'h0001;
   endproperty
   a_rd_inc: assert property (p_rd_inc) // RULE_19
      else $error("counter not advanced after read byte");

   property p_busy_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(write_busy) |-> write_busy [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) // RULE_26
      else $error("write cycle ended too early");

   property p_go;
      @(posedge sys_clk) disable iff (!rst_n)
      go_write |=> write_busy && timer_reg == 24'h000000;
   endproperty
   a_go: assert property (p_go) // RULE_09
      else $error("valid stop did not start write");

   property p_no_go;
      @(posedge sys_clk) disable iff (!rst_n)
      (stop_det && !armed_reg && !write_busy) |=> !write_busy;
   endproperty
   a_no_go: assert property (p_no_go) // RULE_09
      else $error("misplaced stop started write");

   property p_rd_nack;
      @(posedge sys_clk) disable iff (!rst_n)
      (scl_rise && state_reg == sea_pkg::SEA_RDAT &&
       cnt_reg == `SEA_BIT_ACK && sda_in && !write_busy)
      |=> state_reg == sea_pkg::SEA_IDLE ##1 !sda_oe;
   endproperty
   a_rd_nack: assert property (p_rd_nack) // RULE_23
      else $error("read continued after master nack");

   property p_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_det && !write_busy && !stop_det)
      |=> state_reg == sea_pkg::SEA_DEV && cnt_reg == 4'h0;
   endproperty
   a_start: assert property (p_start) // RULE_22
      else $error("start not recognised");

endmodule

// [dv/sea_mst.sv]
module sea_mst (
   // Clock
   input  wire logic sys_clk,
   // Bus lines
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda_bus
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both lines released at time zero
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Start (1,0) or stop (0,1): data moves while clock is high
   task automatic cond(input logic a, input logic b);
      scl <= 1'b0;
      repeat (2) @(posedge sys_clk);
      sda_drv <= a;
      repeat (2) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sda_drv <= b;
      repeat (3) @(posedge sys_clk);
   endtask

   // One bit slot: data set in low phase, line sampled mid high phase
   task automatic slot(input logic b, output logic r);
      scl <= 1'b0;
      repeat (2) @(posedge sys_clk);
      sda_drv <= b;
      repeat (2) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 r = sda_bus;
      @(posedge sys_clk);
   endtask

   // Byte out, then the slave's answer in the ninth slot
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) slot(d[i], r);
      slot(1'b1, r);
      ack = ~r;
   endtask

   // Byte in; nack set on the last byte of a read
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(nack, r);
   endtask
endmodule

// [dv/sea_eeprom_bench.sv]
module sea_eeprom_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary type code
   localparam int         WCYC    = 200;

   logic       sys_clk = 1'b0;
   logic       rst_n   = 1'b0;
   logic       sda_out;
   logic       sda_oe;
   logic       write_busy;
   logic       scl;
   logic       sda_drv;
   logic       wp      = 1'b0;
   logic [2:0] cs      = 3'h5;
   logic       ack;
   logic [7:0] rd [0:7];
   time        t0;
   int         err_count;
   int         checked;
   wire        sda_line;

   // Pulled-up data line, either party may pull it low
   assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

   // Clock generator
   always #20 sys_clk = ~sys_clk;

   sea_eeprom #(.DEV_TYPE_ID(TYPE_ID), .WRITE_CYCLES(WCYC)) u_dut (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .scl                (scl),
      .sda_in             (sda_line),
      .sda_out            (sda_out),
      .sda_oe             (sda_oe),
      .chip_select_pin_0  (cs[0]),
      .chip_select_pin_1  (cs[1]),
      .chip_select_pin_2  (cs[2]),
      .write_protect_input(wp),
      .write_busy         (write_busy)
   );

   sea_mst u_mst (
      .sys_clk(sys_clk),
      .scl    (scl),
      .sda_drv(sda_drv),
      .sda_bus(sda_line)
   );

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic final_report;
      $display("mismatches %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Start and select byte
   task automatic sel(input logic rw, input logic [3:0] id,
                      input logic [2:0] c, output logic a);
      u_mst.cond(1'b1, 1'b0);
      u_mst.put_byte({id, c, rw}, a);
   endtask

   // Write select and both address bytes, each acknowledged
   task automatic addr_phase(input logic [15:0] a);
      sel(1'b0, TYPE_ID, cs, ack);
      check(ack, 1'b1);
      u_mst.put_byte(a[15:8], ack);
      check(ack, 1'b1);
      u_mst.put_byte(a[7:0], ack);
      check(ack, 1'b1);
   endtask

   // Byte or page write, busy polling and busy length
   task automatic wr(input logic [15:0] a, input int n,
                     input logic [7:0] base, input logic ok);
      addr_phase(a);
      for (int i = 0; i < n; i++) begin
         u_mst.put_byte(base + 8'(i), ack);
         check(ack, ok);
      end
      u_mst.cond(1'b0, 1'b1);
      #1 check(write_busy, ok);
      t0 = $time;
      @(posedge sys_clk);
      if (ok) begin
         sel(1'b0, TYPE_ID, cs, ack);
         check(ack, 1'b0);
         u_mst.cond(1'b0, 1'b1);
         for (int k = 0; k < 400 && write_busy !== 1'b0; k++)
            @(posedge sys_clk);
         check(16'((($time - t0) / 40) inside {[WCYC - 6:WCYC]}), 1);
         sel(1'b0, TYPE_ID, cs, ack);
         check(ack, 1'b1);
         u_mst.cond(1'b0, 1'b1);
         #1 check(write_busy, 1'b0);
         @(posedge sys_clk);
      end
   endtask

   // Current (rnd=0) or random (rnd=1) read of n bytes into rd
   task automatic rdseq(input logic [15:0] a, input logic rnd, input int n);
      if (rnd)
         addr_phase(a);
      sel(1'b1, TYPE_ID, cs, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++)
         u_mst.get_byte(i == n - 1, rd[i]);
      u_mst.cond(1'b0, 1'b1);
      #1 check(sda_oe, 1'b0);
      check(sda_out, 1'b0);
      @(posedge sys_clk);
   endtask

   // Data line stays released while the write cycle runs
   always @(negedge sys_clk) begin
      if (write_busy === 1'b1)
         check(sda_oe, 1'b0);
   end

   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      final_report;
   end

   // Test sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 check(write_busy, 1'b0);
      @(posedge sys_clk);
      // Erased array, counter at zero
      rdseq(16'h0000, 1'b0, 1);
      check(rd[0], 8'hff);
      // Foreign type code and chip codes stay silent
      sel(1'b0, ~TYPE_ID, cs, ack);
      check(ack, 1'b0);
      for (int i = 0; i < 3; i++) begin
         sel(1'b0, TYPE_ID, cs ^ (3'h1 << i), ack);
         check(ack, 1'b0);
      end
      u_mst.cond(1'b0, 1'b1);
      // Byte writes, then a page across two words
      wr(16'h0000, 1, 8'h5a, 1'b1);
      wr(16'h0106, 1, 8'h77, 1'b1);
      wr(16'h0102, 4, 8'ha0, 1'b1);
      rdseq(16'h0000, 1'b0, 1);
      check(rd[0], 8'h77);
      rdseq(16'h0100, 1'b1, 6);
      for (int i = 0; i < 6; i++)
         check(rd[i], (i < 2) ? 8'hff : 8'ha0 + 8'(i - 2));
      rdseq(16'h0000, 1'b0, 1);
      check(rd[0], 8'h77);
      // Page write wraps inside its row
      wr(16'h037e, 4, 8'hc0, 1'b1);
      rdseq(16'h037e, 1'b1, 3);
      check({rd[0], rd[1]}, 16'hc0c1);
      check(rd[2], 8'hff);
      rdseq(16'h0300, 1'b1, 2);
      check({rd[0], rd[1]}, 16'hc2c3);
      // Protected write, reads unaffected by protection
      wp <= 1'b1;
      wr(16'h0000, 2, 8'h11, 1'b0);
      rdseq(16'h0000, 1'b1, 1);
      check(rd[0], 8'h5a);
      wp <= 1'b0;
      // Stop right after the address bytes starts nothing
      addr_phase(16'h0000);
      u_mst.cond(1'b0, 1'b1);
      #1 check(write_busy, 1'b0);
      @(posedge sys_clk);
      // Sequential read rolls over to address zero
      rdseq(16'hffff, 1'b1, 2);
      check({rd[0], rd[1]}, 16'hff5a);
      final_report;
   end
endmodule
